// [shared/swd_map.svh]
// Constants for the software watchdog: control bit reset values and counts.
// Assumes inclusion by bare name from design files.
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH
`define SWD_ENABLE_RST 1'h1
`define SWD_RSTSEL_RST 1'h1
`define SWD_PRESCALE_RST 1'h0
`define SWD_PRESCALE_DIV 32'h00010000
`define SWD_TERMINAL_DEF 32'h0000ffff
`define SWD_ACCESS_BITS 6'h20
`endif

// [shared/swd_pkg.sv]
// Types for the software watchdog.
// Assumes nothing beyond a SystemVerilog compiler.
package swd_pkg;
    typedef enum logic [2:0] {
        SWD_IDLE = 3'b001,
        SWD_RUN = 3'b010,
        SWD_EXPIRED = 3'b100
    } swd_state_e;
endpackage

// [sim/swd_core_model.sv]
// Core-side model: counts hard reset and machine check requests.
// Assumes request levels come from the watchdog on the same clock.
`timescale 1ns/1ns
`default_nettype none
module swd_core_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Requests from the watchdog.
    input wire logic hardResetReq,
    input wire logic machineCheckReq,
    // Event counts.
    output logic [15:0] nHard,
    output logic [15:0] nMcp
);
    logic prevHard;
    logic prevMcp;
    // A held level is one event; the reset is not fed back, so the bench
    // can go on after a timeout.
    always_ff @(posedge clock) begin
        prevHard <= rst_n & hardResetReq;
        prevMcp <= rst_n & machineCheckReq;
        if (!rst_n) begin
            nHard <= 16'h0;
            nMcp <= 16'h0;
        end else begin
            nHard <= nHard + 16'(hardResetReq & ~prevHard);
            nMcp <= nMcp + 16'(machineCheckReq & ~prevMcp);
        end
    end
endmodule
`default_nettype wire

// [sim/swd_watchdog_test.sv]
// Bench for the watchdog: modes, refused writes, service and timeouts.
// Assumes the watchdog and core model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module swd_watchdog_test;
    localparam int TERM = 8;
    logic clock = 0, rst_n = 0, ctrlWrite = 0, service = 0;
    logic ctrlEnable = 0, ctrlResetSel = 0, ctrlPrescale = 0;
    logic [5:0] ctrlSize = 6'h20;
    logic en, sel, pre, hrd, mcp;
    logic [31:0] count;
    logic [15:0] nHard, nMcp;
    int num_errors = 0, checks_done = 0, seed = 14346, n, k;
    // Clock of 8 ns period.
    always #4 clock = ~clock;
    swd_watchdog #(.TERMINAL(32'(TERM))) dut (.clock(clock), .rst_n(rst_n),
        .ctrlWrite(ctrlWrite), .ctrlSize(ctrlSize), .ctrlEnable(ctrlEnable),
        .ctrlResetSel(ctrlResetSel), .ctrlPrescale(ctrlPrescale),
        .service(service), .watchdogEnableBit(en),
        .resetOrInterruptSelect(sel), .counterPrescaleSelect(pre),
        .hardResetReq(hrd), .machineCheckReq(mcp), .count(count));
    swd_core_model core (.clock(clock), .rst_n(rst_n), .hardResetReq(hrd),
        .machineCheckReq(mcp), .nHard(nHard), .nMcp(nMcp));
    // Expiry comes TERM+1 ticks plus a few cycles of state changes later.
    function automatic logic inTime(input int c);
        return c >= TERM + 1 && c <= TERM + 4;
    endfunction
    task automatic chk(input logic [63:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Strobes are held from one falling edge to the next.
    task automatic wr(input logic e, s, p, input logic [5:0] sz);
        @(negedge clock);
        {ctrlWrite, ctrlEnable, ctrlResetSel, ctrlPrescale} = {1'b1, e, s, p};
        ctrlSize = sz;
        @(negedge clock);
        ctrlWrite = 0;
    endtask
    task automatic svc();
        @(negedge clock);
        service = 1;
        @(negedge clock);
        service = 0;
    endtask
    // A wait that runs out ends the run as a failure.
    task automatic waitReq(input int lim);
        for (n = 0; n < lim && (hrd | mcp) !== 1'b1; n++) @(negedge clock);
        if (n == lim) begin
            num_errors++;
            results();
        end
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1;
        chk({en, sel, pre, hrd, mcp, count}, 37'h18_0000_0000);
        waitReq(TERM + 6);
        chk({inTime(n), hrd, mcp}, 3'b110);
        wr(1'b0, 1'b0, 1'b1, 6'h10);
        chk({en, sel, pre}, 3'b110);
        // Random short writes while expired must leave every bit alone.
        for (int i = 0; i < 4; i++) begin
            k = $random(seed);
            wr(k[0], k[1], k[2], {1'b0, k[7:3]});
            chk({en, sel, pre}, 3'b110);
        end
        $display("reset mode done");
        svc();
        @(negedge clock);
        chk({hrd, mcp, nHard}, 18'h1);
        wr(1'b0, 1'b1, 1'b0, 6'h20);
        repeat (3 * TERM) @(negedge clock);
        chk({en, hrd, mcp, count}, 35'h0);
        wr(1'b1, 1'b0, 1'b0, 6'h20);
        waitReq(TERM + 6);
        chk({inTime(n), hrd, mcp}, 3'b101);
        // The core model counts a new level one edge after it appears.
        @(negedge clock);
        chk(nMcp, 16'h1);
        $display("interrupt mode done");
        // Services at random gaps below the terminal count never expire.
        for (int i = 0; i < 16; i++) begin
            svc();
            k = $unsigned($random(seed)) % TERM;
            repeat (k) @(negedge clock);
            chk({hrd, mcp}, 2'b00);
        end
        $display("random service done");
        wr(1'b1, 1'b1, 1'b1, 6'h20);
        svc();
        repeat (100) @(negedge clock);
        chk(count, 32'h0);
        for (n = 100; n < 70000 && count === 32'h0; n++) @(negedge clock);
        chk(n >= 65530 && n <= 65545, 1'b1);
        $display("prescale done");
        // A reset in mid-run brings every bit back to its reset value.
        wr(1'b0, 1'b0, 1'b1, 6'h20);
        chk({en, sel, pre}, 3'b001);
        rst_n = 0;
        repeat (2) @(negedge clock);
        rst_n = 1;
        chk({en, sel, pre, hrd, mcp, count}, 37'h18_0000_0000);
        $display("mid-run reset done");
        results();
    end
endmodule
`default_nettype wire

// [verilog/swd_watchdog.sv]
// Software watchdog with enable, prescale and reset-or-interrupt select.
// Assumes control bits come from logic on the same clock as plain inputs.
// Functional notes
// - Watchdog runs only while enable is 1; enable resets to 1.
// - With enable 0, counter and prescaler stay stopped; no timeout.
// - Unserviced enabled watchdog times out, giving reset or interrupt.
// - Select 1 makes timeout a hard reset; select resets to 1.
// - Select 0 makes timeout a machine check interrupt request.
// - Prescale 1 divides counter clock by 65,536; 0 gives no division.
// - Control accesses are 32 bits only; other sizes are refused.
`timescale 1ns/1ns
`default_nettype none
`include "swd_map.svh"
module swd_watchdog #(
    parameter logic [31:0] TERMINAL = `SWD_TERMINAL_DEF
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Control register write port.
    input wire logic ctrlWrite,
    input wire logic [5:0] ctrlSize,
    input wire logic ctrlEnable,
    input wire logic ctrlResetSel,
    input wire logic ctrlPrescale,
    // Service strobe from software.
    input wire logic service,
    // Status and outputs.
    output logic watchdogEnableBit,
    output logic resetOrInterruptSelect,
    output logic counterPrescaleSelect,
    output logic hardResetReq,
    output logic machineCheckReq,
    output logic [31:0] count
);
    swd_pkg::swd_state_e state;
    logic [15:0] prescaler;
    logic tick;
    logic sizeOk;
    logic expire;

    // Only full-word writes reach the control bits.
    assign sizeOk = ctrlWrite && (ctrlSize == `SWD_ACCESS_BITS);

    // Counter advances every cycle, or once per full prescaler wrap.
    assign tick = !counterPrescaleSelect ||
        (prescaler == 16'(`SWD_PRESCALE_DIV - 32'h1));
    assign expire = (state == swd_pkg::SWD_RUN) && tick &&
        (count == TERMINAL);

    // Control bits take their reset values and follow accepted writes.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            watchdogEnableBit <= `SWD_ENABLE_RST;
            resetOrInterruptSelect <= `SWD_RSTSEL_RST;
            counterPrescaleSelect <= `SWD_PRESCALE_RST;
        end else if (sizeOk) begin
            watchdogEnableBit <= ctrlEnable;
            resetOrInterruptSelect <= ctrlResetSel;
            counterPrescaleSelect <= ctrlPrescale;
        end
    end

    // State follows enable; expiry is held until service or disable.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= swd_pkg::SWD_IDLE;
        end else begin
            case (state)
                swd_pkg::SWD_IDLE: begin
                    if (watchdogEnableBit) begin
                        state <= swd_pkg::SWD_RUN;
                    end
                end
                swd_pkg::SWD_RUN: begin
                    if (!watchdogEnableBit) begin
                        state <= swd_pkg::SWD_IDLE;
                    end else if (expire && !service) begin
                        state <= swd_pkg::SWD_EXPIRED;
                    end
                end
                swd_pkg::SWD_EXPIRED: begin
                    if (!watchdogEnableBit || service) begin
                        state <= swd_pkg::SWD_IDLE;
                    end
                end
                default: begin
                    state <= swd_pkg::SWD_IDLE;
                end
            endcase
        end
    end

    // Counter and prescaler stop when not running; service restarts both.
    always_ff @(posedge clock) begin
        if (!rst_n || service || state != swd_pkg::SWD_RUN) begin
            prescaler <= 16'h0000;
            count <= 32'h00000000;
        end else begin
            if (counterPrescaleSelect) begin
                prescaler <= prescaler + 16'h0001;
            end
            if (tick && count != TERMINAL) begin
                count <= count + 32'h00000001;
            end
        end
    end

    // Outcome follows the select bit; outputs hold through expiry.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hardResetReq <= 1'b0;
            machineCheckReq <= 1'b0;
        end else begin
            hardResetReq <= (state == swd_pkg::SWD_EXPIRED) &&
                watchdogEnableBit && !service && resetOrInterruptSelect;
            machineCheckReq <= (state == swd_pkg::SWD_EXPIRED) &&
                watchdogEnableBit && !service && !resetOrInterruptSelect;
        end
    end

    // Disabled watchdog: counter, prescaler and outputs stay quiet.
    AST_DISABLED_STILL: assert property (
        @(posedge clock) disable iff (!rst_n)
        !watchdogEnableBit |=> ##1 count == 32'h0)
        else $error("Counter moved while disabled.");
    AST_NO_OUT_DISABLED: assert property (
        @(posedge clock) disable iff (!rst_n)
        !watchdogEnableBit |=> !hardResetReq && !machineCheckReq)
        else $error("Timeout output while disabled.");
    AST_STOPPED: assert property (
        @(posedge clock) disable iff (!rst_n)
        state != swd_pkg::SWD_RUN |=> prescaler == 16'h0 && count == 32'h0)
        else $error("Counter or prescaler moved outside run.");
    AST_IDLE_DISABLED: assert property (
        @(posedge clock) disable iff (!rst_n)
        !watchdogEnableBit |=> state == swd_pkg::SWD_IDLE)
        else $error("Watchdog ran while disabled.");

    // Timeout: expiry leads to exactly one output, chosen by the select.
    AST_EXPIRE_STATE: assert property (
        @(posedge clock) disable iff (!rst_n)
        expire && !service && watchdogEnableBit |=>
        state == swd_pkg::SWD_EXPIRED)
        else $error("Terminal count did not expire.");
    AST_EXPIRE_OUT: assert property (
        @(posedge clock) disable iff (!rst_n)
        expire && !service && watchdogEnableBit ##1
        (watchdogEnableBit && !service) |=>
        (hardResetReq || machineCheckReq))
        else $error("Timeout gave no output.");
    AST_ONE_OUT: assert property (
        @(posedge clock) disable iff (!rst_n)
        !(hardResetReq && machineCheckReq))
        else $error("Both outputs active.");
    AST_RESET_SEL: assert property (
        @(posedge clock) disable iff (!rst_n)
        hardResetReq |-> $past(resetOrInterruptSelect))
        else $error("Hard reset with interrupt selected.");
    AST_HARD_HOLD: assert property (
        @(posedge clock) disable iff (!rst_n)
        hardResetReq && watchdogEnableBit && !service &&
        resetOrInterruptSelect |=> hardResetReq)
        else $error("Hard reset request dropped early.");
    AST_MCP_SEL: assert property (
        @(posedge clock) disable iff (!rst_n)
        machineCheckReq |-> !$past(resetOrInterruptSelect))
        else $error("Interrupt with reset selected.");
    AST_MCP_HOLD: assert property (
        @(posedge clock) disable iff (!rst_n)
        machineCheckReq && watchdogEnableBit && !service &&
        !resetOrInterruptSelect |=> machineCheckReq)
        else $error("Interrupt request dropped early.");

    // Counter steps every cycle unprescaled, once per wrap when prescaled.
    // Holds are only claimed while running; leaving run clears the count.
    AST_NOPRESC: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == swd_pkg::SWD_RUN && !counterPrescaleSelect && !service &&
        count != TERMINAL |=> count == $past(count) + 32'h1)
        else $error("Unprescaled counter did not step.");
    AST_PRESC_HOLD: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == swd_pkg::SWD_RUN && counterPrescaleSelect && !tick &&
        !service |=> count == $past(count))
        else $error("Prescaled counter stepped early.");
    AST_PRESC_STEP: assert property (
        @(posedge clock) disable iff (!rst_n)
        state == swd_pkg::SWD_RUN && counterPrescaleSelect && tick &&
        !service && count != TERMINAL |=> count == $past(count) + 32'h1)
        else $error("Prescaled counter missed its step.");
    AST_SERVICE: assert property (
        @(posedge clock) disable iff (!rst_n)
        service |=> count == 32'h0 && prescaler == 16'h0)
        else $error("Service did not restart counter.");

    // Control writes: full words land, any other size changes nothing.
    AST_SIZE: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrlWrite && ctrlSize != `SWD_ACCESS_BITS |=>
        $stable(watchdogEnableBit))
        else $error("Short write changed control.");
    AST_SIZE_ALL: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrlWrite && ctrlSize != `SWD_ACCESS_BITS |=>
        $stable(resetOrInterruptSelect) && $stable(counterPrescaleSelect))
        else $error("Short write changed a select bit.");
    AST_WRITE_TAKEN: assert property (
        @(posedge clock) disable iff (!rst_n)
        sizeOk |=> watchdogEnableBit == $past(ctrlEnable) &&
        resetOrInterruptSelect == $past(ctrlResetSel) &&
        counterPrescaleSelect == $past(ctrlPrescale))
        else $error("Full-word write did not land.");

    // Reset values hold at the first edge after every release.
    AST_ENABLE_RST: assert property (
        @(posedge clock)
        $rose(rst_n) |-> watchdogEnableBit)
        else $error("Enable not set after reset.");
    AST_RST_VALUES: assert property (
        @(posedge clock)
        $rose(rst_n) |-> resetOrInterruptSelect && !counterPrescaleSelect)
        else $error("Select bits not at reset values.");

    // Main scenarios that the bench is expected to reach.
    COV_RESET: cover property (@(posedge clock) hardResetReq);
    COV_MCP: cover property (@(posedge clock) machineCheckReq);
    COV_SERVICE: cover property (@(posedge clock)
        service && state == swd_pkg::SWD_RUN);
    COV_DISABLE: cover property (@(posedge clock)
        sizeOk && !ctrlEnable);
    COV_PRESC_TICK: cover property (@(posedge clock)
        state == swd_pkg::SWD_RUN && counterPrescaleSelect && tick);
endmodule
`default_nettype wire
